// ### include/opdec_defs.svh
// How it works
// - Destinations take register, direct or indirect; immediate and table only as sources.
// - Except plain moves, a destination operand is read before it is written.
// - The destination/source field picks data type, method and operands.
// - Working registers reachable by register mode, or directly/indirectly in RAM.
// - Internal RAM bytes 0 to 127 answer direct and indirect addressing.
// - Internal RAM bytes 128 to 255 are reached only indirectly.
// - A direct address 128 to 255 selects the special function space.
// - Auxiliary RAM 0 to 1791 only through the external move, never direct.
// - External data memory only indirectly, address taken from a pointer.
// - Table reads from program memory add index register to base register.
// - Bit address 8k plus n below 128 is bit n of RAM byte 20H plus k; from 128 up it is bit n of SFR byte 8k.
// - Four banks of eight registers fill RAM 0 to 31, one active.
// - Indirect internal RAM uses pointer register zero or one of active bank.
`ifndef OPDEC_DEFS_SVH
`define OPDEC_DEFS_SVH

// ***************************************************************
// Memory map limits.
// ***************************************************************
`define LOWER_RAM_TOP    8'h7f
`define SFR_BASE         8'h80
`define BIT_RAM_BASE     8'h20
`define BIT_SPACE_TOP    8'h7f
`define BANK_REGS        4'h8
`define AUX_RAM_TOP      16'h06ff
`define AUX_PAGE_INVALID 3'h7

// ***************************************************************
// Reset values.
// ***************************************************************
`define ADDR_RESET       16'h0000
`define BIT_POS_RESET    3'h0
`define PTR_ADDR_RESET   8'h00

`endif

// ### include/opdec_pkg.sv
package opdec_pkg;

    // ***************************************************************
    // Addressing methods, operand roles and storage targets.
    // ***************************************************************
    typedef enum logic [2:0] {
        METHOD_REGISTER,
        METHOD_DIRECT,
        METHOD_REG_INDIRECT,
        METHOD_IMMEDIATE,
        METHOD_BASE_INDEX,
        METHOD_BIT
    } addr_method_t;

    typedef enum logic {
        ROLE_SOURCE,
        ROLE_DESTINATION
    } operand_role_t;

    typedef enum logic [2:0] {
        TARGET_NONE,
        TARGET_LOWER_RAM,
        TARGET_UPPER_RAM,
        TARGET_SFR,
        TARGET_AUX_RAM,
        TARGET_EXT_DATA,
        TARGET_PROG_MEM,
        TARGET_IMMEDIATE
    } mem_target_t;

    // ***************************************************************
    // Destination/source field handed over by instruction decode.
    // ***************************************************************
    typedef struct packed {
        logic          valid;
        operand_role_t role;
        addr_method_t  method;
        logic [7:0]    operand;
        logic          pointer_sel;
        logic          external_move_instruction;
        logic          ext_via_data_pointer;
        logic          base_is_pc;
        logic          plain_move;
    } operand_field_t;

    // ***************************************************************
    // Core state the decoder needs.
    // ***************************************************************
    typedef struct packed {
        logic [1:0]  active_bank;
        logic [7:0]  pointer_value;
        logic [15:0] data_pointer;
        logic [15:0] program_counter;
        logic [7:0]  index_value;
        logic [2:0]  aux_page;
        logic        aux_disable;
    } core_state_t;

    // ***************************************************************
    // Decoded operand access.
    // ***************************************************************
    typedef struct packed {
        logic        valid;
        mem_target_t target;
        logic [15:0] address;
        logic        bit_access;
        logic [2:0]  bit_pos;
        logic        read_en;
        logic        write_en;
        logic        illegal;
    } operand_access_t;

endpackage

// ### src/operand_address_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "opdec_defs.svh"

module operand_address_decoder (
    // Clock and reset.
    input  wire logic                     clk_sys_in,
    input  wire logic                     rst_in,
    // Operand request from instruction decode.
    input  wire opdec_pkg::operand_field_t field_in,
    input  wire opdec_pkg::core_state_t    state_in,
    // Decoded access towards the memories.
    output var  opdec_pkg::operand_access_t access_out,
    output var  logic [7:0]                pointer_addr_out
);
    import opdec_pkg::*;

    // ***************************************************************
    // Working values of the decode.
    // ***************************************************************
    operand_access_t access_d;
    operand_access_t access_q;
    logic [7:0]      pointer_addr_d;
    logic [7:0]      pointer_addr_q;
    logic            is_destination;
    logic            dest_legal;
    logic [7:0]      reg_ram_addr;
    logic [7:0]      bit_byte_addr;
    logic [10:0]     aux_page_addr;
    logic [15:0]     table_base;
    logic            dp_in_aux;
    logic            page_valid;
    logic            role_read;
    logic            role_write;

    // ***************************************************************
    // Per-method decode results.
    // ***************************************************************
    mem_target_t     reg_target;
    logic [15:0]     reg_addr;
    mem_target_t     dir_target;
    logic [15:0]     dir_addr;
    mem_target_t     ind_target;
    logic [15:0]     ind_addr;
    mem_target_t     ext_target;
    logic [15:0]     ext_addr;
    logic            ext_illegal;
    mem_target_t     imm_target;
    logic [15:0]     imm_addr;
    mem_target_t     tab_target;
    logic [15:0]     tab_addr;
    mem_target_t     bit_target;
    logic [15:0]     bit_addr;
    logic [2:0]      bit_pos;

    // ***************************************************************
    // Selected decode.
    // ***************************************************************
    mem_target_t     sel_target;
    logic [15:0]     sel_addr;
    logic            sel_illegal;
    logic            sel_bit;
    logic [2:0]      sel_bit_pos;
    logic            grant;

    // ***************************************************************
    // Address helpers.
    // ***************************************************************
    assign reg_ram_addr   = {3'h0, state_in.active_bank,
                             field_in.operand[2:0]};
    assign bit_byte_addr  = `BIT_RAM_BASE +
                            {4'h0, field_in.operand[6:3]};
    assign aux_page_addr  = {state_in.aux_page, state_in.pointer_value};
    assign table_base     = field_in.base_is_pc ? state_in.program_counter :
                                                  state_in.data_pointer;
    assign is_destination = (field_in.role == ROLE_DESTINATION);

    // ***************************************************************
    // Auxiliary RAM window checks.
    // ***************************************************************
    assign dp_in_aux  = !state_in.aux_disable &&
                        (state_in.data_pointer <= `AUX_RAM_TOP);
    assign page_valid = (state_in.aux_page != `AUX_PAGE_INVALID);

    // ***************************************************************
    // Destination legality.
    // ***************************************************************
    // Only register, direct, register-indirect and bit forms may be written.
    always_comb begin
        dest_legal = 1'b0;
        unique case (field_in.method)
            METHOD_REGISTER,
            METHOD_DIRECT,
            METHOD_REG_INDIRECT,
            METHOD_BIT: begin
                dest_legal = 1'b1;
            end
            METHOD_IMMEDIATE,
            METHOD_BASE_INDEX: begin
                dest_legal = !is_destination;
            end
            default: begin
                dest_legal = 1'b0;
            end
        endcase
    end

    // ***************************************************************
    // Register addressing.
    // ***************************************************************
    always_comb begin
        reg_target = TARGET_LOWER_RAM;
        reg_addr   = {8'h00, reg_ram_addr};
    end

    // ***************************************************************
    // Direct addressing.
    // ***************************************************************
    always_comb begin
        dir_addr = {8'h00, field_in.operand};
        if (field_in.operand <= `LOWER_RAM_TOP) begin
            dir_target = TARGET_LOWER_RAM;
        end else begin
            dir_target = TARGET_SFR;
        end
    end

    // ***************************************************************
    // Register-indirect addressing of internal RAM.
    // ***************************************************************
    always_comb begin
        ind_addr = {8'h00, state_in.pointer_value};
        if (state_in.pointer_value <= `LOWER_RAM_TOP) begin
            ind_target = TARGET_LOWER_RAM;
        end else begin
            ind_target = TARGET_UPPER_RAM;
        end
    end

    // ***************************************************************
    // External move routing.
    // ***************************************************************
    always_comb begin
        ext_illegal = 1'b0;
        ext_target  = TARGET_NONE;
        ext_addr    = `ADDR_RESET;
        if (field_in.ext_via_data_pointer) begin
            ext_addr = state_in.data_pointer;
            if (dp_in_aux) begin
                ext_target = TARGET_AUX_RAM;
            end else begin
                ext_target = TARGET_EXT_DATA;
            end
        end else if (state_in.aux_disable) begin
            ext_target = TARGET_EXT_DATA;
            ext_addr   = {8'h00, state_in.pointer_value};
        end else if (page_valid) begin
            ext_target = TARGET_AUX_RAM;
            ext_addr   = {5'h00, aux_page_addr};
        end else begin
            ext_illegal = 1'b1;
        end
    end

    // ***************************************************************
    // Immediate and table operands.
    // ***************************************************************
    always_comb begin
        imm_target = TARGET_IMMEDIATE;
        imm_addr   = {8'h00, field_in.operand};
        tab_target = TARGET_PROG_MEM;
        tab_addr   = 16'(table_base +
                         {8'h00, state_in.index_value});
    end

    // ***************************************************************
    // Bit addressing.
    // ***************************************************************
    always_comb begin
        bit_pos = field_in.operand[2:0];
        if (field_in.operand <= `BIT_SPACE_TOP) begin
            bit_target = TARGET_LOWER_RAM;
            bit_addr   = {8'h00, bit_byte_addr};
        end else begin
            bit_target = TARGET_SFR;
            bit_addr   = {8'h00, field_in.operand[7:3], 3'h0};
        end
    end

    // ***************************************************************
    // Method selection.
    // ***************************************************************
    always_comb begin
        sel_target  = TARGET_NONE;
        sel_addr    = `ADDR_RESET;
        sel_illegal = 1'b0;
        sel_bit     = 1'b0;
        sel_bit_pos = `BIT_POS_RESET;
        unique case (field_in.method)
            METHOD_REGISTER: begin
                sel_target = reg_target;
                sel_addr   = reg_addr;
            end
            METHOD_DIRECT: begin
                sel_target = dir_target;
                sel_addr   = dir_addr;
            end
            METHOD_REG_INDIRECT: begin
                if (field_in.external_move_instruction) begin
                    sel_target  = ext_target;
                    sel_addr    = ext_addr;
                    sel_illegal = ext_illegal;
                end else begin
                    sel_target = ind_target;
                    sel_addr   = ind_addr;
                end
            end
            METHOD_IMMEDIATE: begin
                sel_target = imm_target;
                sel_addr   = imm_addr;
            end
            METHOD_BASE_INDEX: begin
                sel_target = tab_target;
                sel_addr   = tab_addr;
            end
            METHOD_BIT: begin
                sel_target  = bit_target;
                sel_addr    = bit_addr;
                sel_bit     = 1'b1;
                sel_bit_pos = bit_pos;
            end
            default: begin
                sel_illegal = 1'b1;
            end
        endcase
        if (!dest_legal) begin
            sel_illegal = 1'b1;
        end
    end

    // ***************************************************************
    // Pointer register location.
    // ***************************************************************
    always_comb begin
        pointer_addr_d = pointer_addr_q;
        if (field_in.method == METHOD_REG_INDIRECT) begin
            pointer_addr_d = {3'h0, state_in.active_bank, 2'h0,
                              field_in.pointer_sel};
        end
    end

    // ***************************************************************
    // Operand roles.
    // ***************************************************************
    assign role_read  = !is_destination || !field_in.plain_move;
    assign role_write = is_destination;

    // ***************************************************************
    // Access assembly.
    // ***************************************************************
    assign grant = field_in.valid && !sel_illegal;

    always_comb begin
        access_d            = '0;
        access_d.valid      = field_in.valid;
        access_d.target     = sel_target;
        access_d.address    = sel_addr;
        access_d.bit_access = sel_bit;
        access_d.bit_pos    = sel_bit_pos;
        access_d.illegal    = field_in.valid && sel_illegal;
        access_d.read_en    = grant && role_read;
        access_d.write_en   = grant && role_write;
    end

    // ***************************************************************
    // Registered access result.
    // ***************************************************************
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            access_q <= '0;
        end else begin
            access_q <= access_d;
        end
    end

    // ***************************************************************
    // Registered pointer register location.
    // ***************************************************************
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pointer_addr_q <= `PTR_ADDR_RESET;
        end else begin
            pointer_addr_q <= pointer_addr_d;
        end
    end

    // ***************************************************************
    // Outputs.
    // ***************************************************************
    assign access_out       = access_q;
    assign pointer_addr_out = pointer_addr_q;

endmodule
`default_nettype wire

// ### tb/operand_address_decoder_chk.sv
`timescale 1ns/1ps
`default_nettype none
module operand_address_decoder_chk
    import opdec_pkg::*;
(
    // Watched ports.
    input wire logic                      clk_sys_in,
    input wire logic                      rst_in,
    input wire opdec_pkg::operand_field_t  field_in,
    input wire opdec_pkg::core_state_t     state_in,
    input wire opdec_pkg::operand_access_t access_out,
    input wire logic [7:0]                pointer_addr_out
);
    operand_field_t f_q;
    core_state_t    s_q;
    logic           ok_q;
    always_ff @(posedge clk_sys_in) begin
        f_q  <= field_in;
        s_q  <= state_in;
        ok_q <= !rst_in && field_in.valid;
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    dest_refused_a: assert property (ok_q && f_q.role
        && f_q.method inside {METHOD_IMMEDIATE, METHOD_BASE_INDEX}
        |-> access_out.illegal && !access_out.write_en)
        else $error("Refused destination accepted.");
    dest_reread_a: assert property (ok_q && f_q.role && !f_q.plain_move
        && f_q.method inside {METHOD_REGISTER, METHOD_DIRECT}
        |-> access_out.read_en && access_out.write_en)
        else $error("Destination not read first.");
    bank_reg_a: assert property (ok_q && f_q.method == METHOD_REGISTER
        |-> access_out.address == {11'h0, s_q.active_bank, f_q.operand[2:0]})
        else $error("Register address wrong.");
    direct_low_a: assert property (ok_q && f_q.method == METHOD_DIRECT
        && !f_q.operand[7] |-> access_out.target == TARGET_LOWER_RAM)
        else $error("Low direct address misrouted.");
    direct_sfr_a: assert property (ok_q && f_q.method == METHOD_DIRECT
        && f_q.operand[7] |-> access_out.target == TARGET_SFR)
        else $error("High direct address misrouted.");
    upper_ind_a: assert property (ok_q && f_q.method == METHOD_REG_INDIRECT
        && !f_q.external_move_instruction && s_q.pointer_value[7]
        |-> access_out.target == TARGET_UPPER_RAM)
        else $error("Upper indirect misrouted.");
    bit_byte_a: assert property (ok_q && f_q.method == METHOD_BIT
        && !f_q.operand[7] |-> access_out.bit_pos == f_q.operand[2:0]
        && access_out.address == 16'h0020 + f_q.operand[6:3])
        else $error("Bit address mapped wrong.");
    table_sum_a: assert property (ok_q && f_q.method == METHOD_BASE_INDEX
        && !f_q.role |-> access_out.address == (f_q.base_is_pc ?
        s_q.program_counter : s_q.data_pointer) + s_q.index_value)
        else $error("Table address wrong.");
    ptr_home_a: assert property (ok_q && f_q.method == METHOD_REG_INDIRECT
        && !f_q.external_move_instruction |-> pointer_addr_out
        == {3'h0, s_q.active_bank, 2'h0, f_q.pointer_sel})
        else $error("Pointer location wrong.");
    ext_route_a: assert property (ok_q && f_q.external_move_instruction
        && f_q.method == METHOD_REG_INDIRECT
        && !f_q.ext_via_data_pointer && s_q.aux_page != 3'h7
        |-> access_out.target == (s_q.aux_disable ? TARGET_EXT_DATA
        : TARGET_AUX_RAM) && access_out.address[7:0] == s_q.pointer_value)
        else $error("External move misrouted.");
    idle_quiet_a: assert property (!field_in.valid |=> !access_out.valid
        && !access_out.write_en) else $error("Output without request.");
endmodule
bind operand_address_decoder operand_address_decoder_chk chk (.*);
`default_nettype wire

// ### tb/operand_address_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin check_count++; if ((got) !== (exp)) begin \
fail_count++; $display("Error %s expected %h seen %h", nm, exp, got); end end
module operand_address_decoder_tb;
    import opdec_pkg::*;
    typedef struct packed {
        operand_access_t a;
        logic            chk_ptr;
        logic [7:0]      ptr;
    } note_t;
    logic            clk_sys_in;
    logic            rst_in;
    operand_field_t  field_in;
    core_state_t     state_in;
    operand_access_t access_out;
    logic [7:0]      pointer_addr_out;
    note_t           exp_q[$];
    note_t           n;
    int              fail_count;
    int              check_count;
    int              seed;
    logic [31:0]     k;
    operand_address_decoder dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .field_in(field_in), .state_in(state_in), .access_out(access_out),
        .pointer_addr_out(pointer_addr_out));
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    task automatic give_verdict();
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic send(input addr_method_t m, input logic r,
        input logic [7:0] op, input mem_target_t t, input logic [15:0] ad,
        input logic ill);
        note_t e;
        field_in.valid = 1'b1;
        field_in.method = m;
        field_in.role = operand_role_t'(r);
        field_in.operand = op;
        e = '0;
        e.a = '{1'b1, t, ad, m == METHOD_BIT, op[2:0],
            !ill && (!r || !field_in.plain_move), !ill && r, ill};
        e.chk_ptr = m == METHOD_REG_INDIRECT
            && !field_in.external_move_instruction;
        e.ptr = {3'h0, state_in.active_bank, 2'h0, field_in.pointer_sel};
        exp_q.push_back(e);
        @(negedge clk_sys_in);
    endtask
    always @(posedge clk_sys_in) begin
        #1;
        if (access_out.valid === 1'b1) begin
            n = exp_q.size() > 0 ? exp_q.pop_front() : '1;
            `CHK("illegal", access_out.illegal, n.a.illegal)
            `CHK("read_en", access_out.read_en, n.a.read_en)
            `CHK("write_en", access_out.write_en, n.a.write_en)
            `CHK("target", access_out.target, n.a.target)
            `CHK("address", access_out.address, n.a.address)
            `CHK("bit_access", access_out.bit_access, n.a.bit_access)
            if (n.a.bit_access)
                `CHK("bit_pos", access_out.bit_pos, n.a.bit_pos)
            if (n.chk_ptr)
                `CHK("pointer", pointer_addr_out, n.ptr)
        end
    end
    initial begin
        repeat (3000) @(posedge clk_sys_in);
        fail_count++;
        give_verdict();
    end
    initial begin
        seed = 32'h3931;
        fail_count = 0;
        check_count = 0;
        rst_in = 1'b1;
        field_in = '0;
        state_in = '{2'h2, 8'ha0, 16'h1234, 16'hfff0, 8'h20, 3'h5, 1'b0};
        repeat (10) @(negedge clk_sys_in);
        rst_in = 1'b0;
        send(METHOD_DIRECT, 1, 8'h90, TARGET_SFR, 16'h0090, 0);
        send(METHOD_DIRECT, 1, 8'h7f, TARGET_LOWER_RAM, 16'h007f, 0);
        send(METHOD_REGISTER, 1, 8'h03, TARGET_LOWER_RAM, 16'h0013, 0);
        field_in.pointer_sel = 1'b1;
        send(METHOD_REG_INDIRECT, 0, 8'h00, TARGET_UPPER_RAM, 16'h00a0, 0);
        state_in.pointer_value = 8'h7f;
        send(METHOD_REG_INDIRECT, 1, 8'h00, TARGET_LOWER_RAM, 16'h007f, 0);
        send(METHOD_BIT, 0, 8'h2b, TARGET_LOWER_RAM, 16'h0025, 0);
        send(METHOD_BIT, 0, 8'h7f, TARGET_LOWER_RAM, 16'h002f, 0);
        send(METHOD_IMMEDIATE, 1, 8'h55, TARGET_IMMEDIATE, 16'h0055, 1);
        send(METHOD_BASE_INDEX, 1, 8'h00, TARGET_PROG_MEM, 16'h1254, 1);
        send(METHOD_IMMEDIATE, 0, 8'h55, TARGET_IMMEDIATE, 16'h0055, 0);
        field_in.base_is_pc = 1'b1;
        send(METHOD_BASE_INDEX, 0, 8'h00, TARGET_PROG_MEM, 16'h0010, 0);
        field_in.base_is_pc = 1'b0;
        send(METHOD_BASE_INDEX, 0, 8'h00, TARGET_PROG_MEM, 16'h1254, 0);
        field_in.plain_move = 1'b1;
        send(METHOD_DIRECT, 1, 8'h30, TARGET_LOWER_RAM, 16'h0030, 0);
        field_in.external_move_instruction = 1'b1;
        state_in.pointer_value = 8'h10;
        send(METHOD_REG_INDIRECT, 0, 8'h00, TARGET_AUX_RAM, 16'h0510, 0);
        state_in.aux_disable = 1'b1;
        send(METHOD_REG_INDIRECT, 0, 8'h00, TARGET_EXT_DATA, 16'h0010, 0);
        state_in = '{2'h1, 8'h10, 16'h06ff, 16'h0, 8'h0, 3'h7, 1'b0};
        send(METHOD_REG_INDIRECT, 0, 8'h00, TARGET_NONE, 16'h0000, 1);
        field_in.ext_via_data_pointer = 1'b1;
        send(METHOD_REG_INDIRECT, 0, 8'h00, TARGET_AUX_RAM, 16'h06ff, 0);
        state_in.data_pointer = 16'h0700;
        send(METHOD_REG_INDIRECT, 0, 8'h00, TARGET_EXT_DATA, 16'h0700, 0);
        field_in = '0;
        @(negedge clk_sys_in);
        repeat (60) begin
            k = $random(seed);
            state_in.active_bank = k[9:8];
            field_in.plain_move = k[10];
            case (k[13:12])
                2'h0: send(METHOD_REGISTER, k[11], k[7:0], TARGET_LOWER_RAM,
                    {11'h0, k[9:8], k[2:0]}, 0);
                2'h1: send(METHOD_DIRECT, k[11], k[7:0], k[7] ? TARGET_SFR
                    : TARGET_LOWER_RAM, {8'h0, k[7:0]}, 0);
                default: send(METHOD_BIT, k[11], k[7:0], k[7] ? TARGET_SFR
                    : TARGET_LOWER_RAM, k[7] ? {8'h0, k[7:3], 3'h0}
                    : 16'h0020 + k[6:3], 0);
            endcase
        end
        field_in.valid = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        `CHK("pending", exp_q.size(), 0)
        give_verdict();
    end
endmodule
`default_nettype wire
